// ### hw/mct_pkg.sv
package mct_pkg;
	// ---------------------------------------------------------------
	// register map (byte addresses, word aligned)
	// ---------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_DIV = 8'h04;
	localparam logic [7:0] OFS_ACTW = 8'h08;
	localparam logic [7:0] OFS_CNT = 8'h0c;
	localparam logic [7:0] OFS_RES = 8'h10;
	localparam logic [7:0] OFS_STAT = 8'h14;

	// ---------------------------------------------------------------
	// control field positions
	// ---------------------------------------------------------------
	localparam int CB_EN = 0;
	localparam int CB_MODE = 1;
	localparam int CB_GNONE = 4;
	localparam int CB_GPOL = 5;
	localparam int CB_EXT = 6;
	localparam int CB_OTYP = 7;
	localparam int CB_STRT = 8;
	localparam int CB_STOP = 10;

	// ---------------------------------------------------------------
	// reset values and constants
	// ---------------------------------------------------------------
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] DIV_RST = 32'h0000_0001;
	localparam logic [31:0] ACTW_RST = 32'h0000_0001;
	localparam logic [31:0] CNT_RST = 32'h0000_0000;
	localparam logic [31:0] CNT_MAX = 32'hffff_ffff;
	localparam logic OUT_RST = 1'b1;
	localparam int TB_HZ = 20_000_000;
	localparam int TB_PERIOD_NS = 1_000_000_000 / TB_HZ;
	localparam logic [4:0] CHAN_CT0 = 5'h11;
	localparam logic [4:0] CHAN_CT1 = 5'h12;

	typedef enum logic [2:0] {
		MD_EVENT = 3'b000,
		MD_UPDN = 3'b001,
		MD_FREQ = 3'b010,
		MD_E2E = 3'b011,
		MD_CE2E = 3'b100,
		MD_RATE = 3'b101,
		MD_ONESHOT = 3'b110,
		MD_REPOS = 3'b111
	} mct_mode_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ARM = 2'b01,
		ST_RUN = 2'b10,
		ST_DONE = 2'b11
	} mct_state_t;

	typedef enum logic [1:0] {
		ES_GRISE = 2'b00,
		ES_GFALL = 2'b01,
		ES_CRISE = 2'b10,
		ES_CFALL = 2'b11
	} mct_edge_t;
endpackage

// ### hw/mct_top.sv
// Summary of operation
// - event count adds one per clock-input rise while gate is active
// - count wraps to zero past full 32 bits and continues
// - up/down: rise increments with gate high, decrements with gate low
// - up/down ignores gate type; gate level is only direction
// - gated frequency count sees no edges before the gate pulse activates
// - start and stop edges each pick rise or fall of gate or clock
// - after start, count every tick until stop, then hold until restarted
// - edge measurement counts at time-base rate, result in base periods
// - continuous mode latches count on each start edge after the first (which only starts counting) and restarts
// - new latch replaces old; stream read returns it then clears it
// - stream read before any completed measurement returns zero
// - rate mode pulses while gate active, stops once gate leaves level
// - rate output at most half time base, or half external clock
// - pulse period from divided time base or from external clock
// - one-shot: one pulse on gate edge, then ignore all inputs
// - one-shot forces full duty cycle
// - repetitive one-shot: one pulse per gate edge until stopped
// - gate edges during a repetitive pulse are ignored
// - repetitive one-shot forces full duty cycle
// - gate and output polarities are software selectable; clock input counts on rise only
// - counter value readable in stream as channel 17 or 18
// - internal counter clock is the fixed time base
// - divider accepts 2 up to 4294967296
// - output type selects which level is active; duty sets active share
module mct_top #(
	parameter logic [4:0] CHAN_ID = mct_pkg::CHAN_CT0
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic ct_clk_in,
	input wire logic ct_gate_in,
	output logic ct_pulse_out,
	input wire logic strm_rd,
	input wire logic [4:0] strm_chan,
	output logic [31:0] strm_data,
	output logic strm_ack
);
	import mct_pkg::*;

	function automatic logic edge_pick(input logic [1:0] sel, input logic gr,
			input logic gf, input logic cr, input logic cf);
		unique case (mct_edge_t'(sel))
			ES_GRISE: edge_pick = gr;
			ES_GFALL: edge_pick = gf;
			ES_CRISE: edge_pick = cr;
			ES_CFALL: edge_pick = cf;
		endcase
	endfunction

	// ---------------------------------------------------------------
	// bus slave
	// ---------------------------------------------------------------
	logic dp_val_r;
	logic dp_wr_r;
	logic [7:0] dp_addr_r;
	logic rd_wait_r;
	logic [31:0] hrdata_r;
	logic [31:0] ctrl_r;
	logic [31:0] div_r;
	logic [31:0] actw_r;
	logic [31:0] cnt_r;
	logic [31:0] res_r;
	logic out_r;
	mct_state_t st_r;
	logic ap_ok;
	logic wr_ok;
	logic go;
	logic cnt_ld;
	logic ctrl_wr;

	assign ap_ok = hsel & hready & htrans[1];
	assign wr_ok = dp_val_r & dp_wr_r;
	assign ctrl_wr = wr_ok & (dp_addr_r == OFS_CTRL);
	assign go = ctrl_wr & hwdata[CB_EN];
	assign cnt_ld = wr_ok & (dp_addr_r == OFS_CNT);
	// one wait state on reads so data written just before is seen
	assign hreadyout = ~rd_wait_r;
	assign hrdata = hrdata_r;
	assign hresp = 1'b0;

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			dp_val_r <= 1'b0;
			dp_wr_r <= 1'b0;
			dp_addr_r <= 8'h00;
			rd_wait_r <= 1'b0;
		end else begin
			dp_val_r <= ap_ok;
			rd_wait_r <= ap_ok & ~hwrite;
			if (ap_ok) begin
				dp_wr_r <= hwrite;
				dp_addr_r <= haddr[7:0];
			end
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			hrdata_r <= 32'h0000_0000;
		end else if (rd_wait_r) begin
			unique case (dp_addr_r)
				OFS_CTRL: hrdata_r <= ctrl_r;
				OFS_DIV: hrdata_r <= div_r;
				OFS_ACTW: hrdata_r <= actw_r;
				OFS_CNT: hrdata_r <= cnt_r;
				OFS_RES: hrdata_r <= res_r;
				OFS_STAT: hrdata_r <= {29'h0, out_r, st_r};
				default: hrdata_r <= 32'h0000_0000;
			endcase
		end
	end

	// divider register holds period minus one, so 1..ffffffff
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_r <= CTRL_RST;
			div_r <= DIV_RST;
			actw_r <= ACTW_RST;
		end else if (wr_ok) begin
			if (dp_addr_r == OFS_CTRL)
				ctrl_r <= hwdata;
			if (dp_addr_r == OFS_DIV)
				div_r <= (hwdata == 32'h0) ? DIV_RST : hwdata;
			if (dp_addr_r == OFS_ACTW)
				actw_r <= hwdata;
		end
	end

	// ---------------------------------------------------------------
	// configuration decode
	// ---------------------------------------------------------------
	mct_mode_t mode;
	logic en;
	logic gnone;
	logic gpol;
	logic ext;
	logic otyp;
	logic is_os;

	assign mode = mct_mode_t'(ctrl_r[CB_MODE +: 3]);
	assign en = ctrl_r[CB_EN];
	assign gnone = ctrl_r[CB_GNONE];
	assign gpol = ctrl_r[CB_GPOL];
	assign ext = ctrl_r[CB_EXT];
	assign otyp = ctrl_r[CB_OTYP];
	assign is_os = (mode == MD_ONESHOT) | (mode == MD_REPOS);

	// ---------------------------------------------------------------
	// input synchronisers and edges
	// ---------------------------------------------------------------
	logic [2:0] csy_r;
	logic [2:0] gsy_r;
	logic c_rise;
	logic c_fall;
	logic g_rise;
	logic g_fall;
	logic g_lvl;
	logic gate_act;
	logic g_trig;
	logic e_start;
	logic e_stop;

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			csy_r <= 3'h0;
			gsy_r <= 3'h0;
		end else begin
			csy_r <= {csy_r[1:0], ct_clk_in};
			gsy_r <= {gsy_r[1:0], ct_gate_in};
		end
	end

	assign c_rise = csy_r[1] & ~csy_r[2];
	assign c_fall = ~csy_r[1] & csy_r[2];
	assign g_rise = gsy_r[1] & ~gsy_r[2];
	assign g_fall = ~gsy_r[1] & gsy_r[2];
	assign g_lvl = gsy_r[1];
	assign gate_act = gnone | (g_lvl == gpol);
	assign g_trig = gpol ? g_rise : g_fall;
	assign e_start = edge_pick(ctrl_r[CB_STRT +: 2], g_rise, g_fall, c_rise, c_fall);
	assign e_stop = edge_pick(ctrl_r[CB_STOP +: 2], g_rise, g_fall, c_rise, c_fall);

	// ---------------------------------------------------------------
	// pulse period generator
	// ---------------------------------------------------------------
	logic [31:0] pcnt_r;
	logic tick;
	logic pend;
	logic gen_on;
	logic act;

	// a single-cycle external tick caps output at half the input rate
	assign tick = ext ? c_rise : 1'b1;
	assign pend = tick & (pcnt_r == div_r);
	assign gen_on = (st_r == ST_RUN) & (((mode == MD_RATE) & gate_act) | is_os);
	assign act = gen_on & (is_os | (pcnt_r < actw_r));

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			pcnt_r <= CNT_RST;
		else if (!gen_on)
			pcnt_r <= CNT_RST;
		else if (pend)
			pcnt_r <= CNT_RST;
		else if (tick)
			pcnt_r <= pcnt_r + 32'h1;
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			out_r <= OUT_RST;
		else
			out_r <= act ? otyp : ~otyp;
	end

	assign ct_pulse_out = out_r;

	// ---------------------------------------------------------------
	// operation state
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= ST_IDLE;
		end else if (ctrl_wr) begin
			if (!hwdata[CB_EN])
				st_r <= ST_IDLE;
			else if (hwdata[CB_MODE +: 3] >= MD_E2E && hwdata[CB_MODE +: 3] != MD_RATE)
				st_r <= ST_ARM;
			else
				st_r <= ST_RUN;
		end else begin
			unique case (st_r)
				ST_IDLE: st_r <= ST_IDLE;
				ST_ARM: begin
					if (is_os ? g_trig : e_start)
						st_r <= ST_RUN;
				end
				ST_RUN: begin
					if (mode == MD_E2E && e_stop)
						st_r <= ST_DONE;
					else if (mode == MD_ONESHOT && pend)
						st_r <= ST_DONE;
					else if (mode == MD_REPOS && pend)
						st_r <= ST_ARM;
				end
				ST_DONE: st_r <= ST_DONE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// counter and latched result
	// ---------------------------------------------------------------
	logic strm_hit;
	logic ce_latch;

	assign strm_hit = strm_rd & (strm_chan == CHAN_ID);
	assign ce_latch = (mode == MD_CE2E) & (st_r == ST_RUN) & e_start;

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_r <= CNT_RST;
		end else if (cnt_ld) begin
			cnt_r <= hwdata;
		end else if (go) begin
			if (hwdata[CB_MODE +: 3] != MD_UPDN)
				cnt_r <= CNT_RST;
		end else if (st_r == ST_RUN) begin
			unique case (mode)
				MD_EVENT, MD_FREQ: begin
					if (c_rise & gate_act)
						cnt_r <= cnt_r + 32'h1;
				end
				MD_UPDN: begin
					if (c_rise)
						cnt_r <= g_lvl ? cnt_r + 32'h1 : cnt_r - 32'h1;
				end
				MD_E2E: begin
					if (!e_stop)
						cnt_r <= cnt_r + 32'h1;
				end
				MD_CE2E: cnt_r <= e_start ? CNT_RST : cnt_r + 32'h1;
				default: cnt_r <= cnt_r;
			endcase
		end else if (st_r == ST_ARM && !is_os && e_start) begin
			cnt_r <= CNT_RST;
		end
	end

	// latch wins over the read clear so no measurement is lost
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			res_r <= CNT_RST;
		else if (ce_latch)
			res_r <= cnt_r;
		else if (go || (strm_hit && mode == MD_CE2E))
			res_r <= CNT_RST;
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			strm_data <= CNT_RST;
			strm_ack <= 1'b0;
		end else begin
			strm_ack <= strm_hit;
			if (strm_hit)
				strm_data <= (mode == MD_CE2E) ? res_r : cnt_r;
		end
	end

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking dc @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	logic quiet;
	assign quiet = !wr_ok;

	a_evt_count: assert property (quiet && st_r == ST_RUN && mode == MD_EVENT
		&& c_rise && gate_act |=> cnt_r == $past(cnt_r) + 32'h1)
		else $error("event count did not step");
	a_evt_gated: assert property (quiet && st_r == ST_RUN && mode == MD_FREQ
		&& !gate_act |=> $stable(cnt_r))
		else $error("count moved outside gate");
	a_cnt_wrap: assert property (quiet && st_r == ST_RUN && mode == MD_EVENT
		&& c_rise && gate_act && cnt_r == CNT_MAX |=> cnt_r == CNT_RST)
		else $error("count did not wrap");
	a_updn_down: assert property (quiet && st_r == ST_RUN && mode == MD_UPDN
		&& c_rise && !g_lvl |=> cnt_r == $past(cnt_r) - 32'h1)
		else $error("down count wrong");
	// no bus transfer may start either: its data phase would land inside the window
	a_e2e_hold: assert property (quiet && !ap_ok && st_r == ST_DONE && mode == MD_E2E
		|=> $stable(cnt_r) [*2])
		else $error("finished measurement moved");
	a_e2e_tick: assert property (quiet && st_r == ST_RUN && mode == MD_E2E
		&& !e_stop |=> cnt_r == $past(cnt_r) + 32'h1)
		else $error("measurement missed a tick");
	a_ce2e_latch: assert property (quiet && ce_latch
		|=> res_r == $past(cnt_r) && cnt_r == CNT_RST)
		else $error("continuous latch wrong");
	a_strm_clear: assert property (strm_hit && mode == MD_CE2E && !ce_latch && quiet
		|=> res_r == CNT_RST && strm_ack)
		else $error("stream read did not clear");
	a_rate_stop: assert property (quiet && mode == MD_RATE && !gate_act
		|=> out_r == ~otyp)
		else $error("rate output kept running");
	a_os_final: assert property (quiet && st_r == ST_DONE && mode == MD_ONESHOT
		|=> st_r == ST_DONE && out_r == ~otyp)
		else $error("one-shot retriggered");

	c_ce2e_latch: cover property (ce_latch ##[1:50] strm_hit);
	c_os_pulse: cover property (st_r == ST_RUN && mode == MD_ONESHOT ##1 st_r == ST_DONE);
	c_rate_period: cover property (gen_on && mode == MD_RATE && pend);
	c_wrap: cover property (cnt_r == CNT_MAX ##1 cnt_r == CNT_RST);
	c_e2e_done: cover property (st_r == ST_RUN && mode == MD_E2E ##1 st_r == ST_DONE);
endmodule

// ### verif/mct_pin_model.sv
module mct_pin_model (
	input wire logic core_clk,
	output logic ct_clk_in,
	output logic ct_gate_in
);
	timeunit 1ns;
	timeprecision 100ps;
	// ---------------------------------------------------------------
	// far-side pins
	// ---------------------------------------------------------------
	// clock pin stands low between bursts, like a gated source
	initial begin
		ct_clk_in = 1'b0;
		ct_gate_in = 1'b0;
	end
	// three cycles a level: the pins pass a two-flop synchroniser
	task automatic clk_pulses(input int n);
		repeat (n) begin
			@(posedge core_clk) ct_clk_in <= 1'b1;
			repeat (3) @(posedge core_clk);
			ct_clk_in <= 1'b0;
			repeat (2) @(posedge core_clk);
		end
	endtask
	task automatic gate(input logic v);
		@(posedge core_clk) ct_gate_in <= v;
	endtask
endmodule

// ### verif/mct_top_tb_top.sv
module mct_top_tb_top;
	import mct_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {
		logic [31:0] ctrl;
		logic [31:0] load;
		logic gate;
		logic [31:0] exp;
	} mct_row_t;
	mct_row_t rows [10] = '{'{32'h61, 32'h0, 1'b1, 32'h5}, '{32'h61, 32'h0, 1'b0, 32'h0},
		'{32'h41, 32'h0, 1'b0, 32'h5}, '{32'h61, 32'hffff_fffe, 1'b1, 32'h3},
		'{32'h65, 32'h0, 1'b0, 32'h0}, '{32'h65, 32'h0, 1'b1, 32'h5},
		'{32'h43, 32'ha, 1'b1, 32'hf}, '{32'h43, 32'ha, 1'b0, 32'h5},
		'{32'h63, 32'ha, 1'b0, 32'h5}, '{32'h53, 32'ha, 1'b1, 32'hf}};
	logic [7:0] ra [6] = '{OFS_CTRL, OFS_DIV, OFS_ACTW, OFS_CNT, OFS_RES, 8'h18};
	logic [31:0] re [6] = '{CTRL_RST, DIV_RST, ACTW_RST, CNT_RST, 32'h0, 32'h0};
	logic core_clk, reset_n, hsel, hwrite, hreadyout, hresp, strm_rd, strm_ack, ack;
	logic ct_clk_in, ct_gate_in, ct_pulse_out;
	logic [31:0] haddr, hwdata, hrdata, strm_data, v, w;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [4:0] strm_chan;
	int bad_count, n_tests, k;

	mct_top dut (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hreadyout),
		.hreadyout(hreadyout),
		.hrdata(hrdata),
		.hresp(hresp),
		.ct_clk_in(ct_clk_in),
		.ct_gate_in(ct_gate_in),
		.ct_pulse_out(ct_pulse_out),
		.strm_rd(strm_rd),
		.strm_chan(strm_chan),
		.strm_data(strm_data),
		.strm_ack(strm_ack)
	);
	mct_pin_model pm (
		.core_clk(core_clk),
		.ct_clk_in(ct_clk_in),
		.ct_gate_in(ct_gate_in)
	);

	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// hreadyout read at the edge itself: the pre-edge value is what the bus samples
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge core_clk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= wr;
		hsize <= 3'b010;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask
	task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
		bus(1'b0, a, 32'h0, d);
	endtask
	task automatic strm(input logic [4:0] c, output logic [31:0] d, output logic a);
		@(posedge core_clk);
		strm_rd <= 1'b1;
		strm_chan <= c;
		@(posedge core_clk);
		strm_rd <= 1'b0;
		#1;
		a = strm_ack;
		d = strm_data;
	endtask
	task automatic cnt_active(input logic lvl, input int n, output int c);
		c = 0;
		repeat (n) begin
			@(posedge core_clk);
			if (ct_pulse_out === lvl) c++;
		end
	endtask
	task automatic e2e(input int n, output logic [31:0] d);
		// gate low first so the start edge is a real rise
		pm.gate(1'b0);
		reg_wr(OFS_CTRL, 32'h407);
		pm.gate(1'b1);
		tick(n);
		pm.gate(1'b0);
		tick(6);
		reg_rd(OFS_CNT, d);
	endtask

	// ---------------------------------------------------------------
	// stimulus
	// ---------------------------------------------------------------
	initial begin
		reset_n = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hsize = 3'b010;
		hwrite = 1'b0;
		hwdata = 32'h0;
		strm_rd = 1'b0;
		strm_chan = 5'h0;
		bad_count = 0;
		n_tests = 0;
		tick(5);
		reset_n <= 1'b1;
		foreach (rows[i]) begin
			reg_wr(OFS_CTRL, rows[i].ctrl);
			reg_wr(OFS_CNT, rows[i].load);
			pm.gate(rows[i].gate);
			tick(4);
			pm.clk_pulses(5);
			tick(4);
			strm(CHAN_CT0, v, ack);
			chk("stream ack", {31'h0, ack}, 32'h1);
			chk("count", v, rows[i].exp);
		end
		strm(CHAN_CT1, v, ack);
		chk("other channel ack", {31'h0, ack}, 32'h0);
		e2e(10, v);
		e2e(20, w);
		chk("interval span", w - v, 32'ha);
		tick(10);
		reg_rd(OFS_CNT, v);
		chk("interval hold", v, w);
		reg_wr(OFS_CTRL, 32'h9);
		strm(CHAN_CT0, v, ack);
		chk("early result", v, 32'h0);
		pm.gate(1'b1);
		tick(3);
		pm.gate(1'b0);
		tick(8);
		pm.gate(1'b1);
		tick(3);
		pm.gate(1'b0);
		strm(CHAN_CT0, v, ack);
		strm(CHAN_CT0, w, ack);
		chk("cleared result", w, 32'h0);
		tick(14);
		pm.gate(1'b1);
		tick(3);
		pm.gate(1'b0);
		tick(3);
		strm(CHAN_CT0, w, ack);
		chk("period span", w - v, 32'ha);
		// both output types; divider 4 then the fastest legal 2
		for (int t = 0; t < 2; t++) begin
			reg_wr(OFS_DIV, t ? 32'h1 : 32'h3);
			reg_wr(OFS_ACTW, 32'h1);
			reg_wr(OFS_CTRL, t ? 32'h2b : 32'hab);
			pm.gate(1'b1);
			tick(10);
			cnt_active(t == 0, 40, k);
			chk("rate active", k, t ? 32'd20 : 32'd10);
			pm.gate(1'b0);
			tick(6);
			cnt_active(t == 0, 20, k);
			chk("rate stopped", k, 32'd0);
		end
		reg_wr(OFS_DIV, 32'h3);
		reg_wr(OFS_CTRL, 32'had);
		pm.gate(1'b1);
		cnt_active(1'b1, 12, k);
		chk("one-shot width", k, 32'd4);
		pm.gate(1'b0);
		tick(3);
		pm.gate(1'b1);
		cnt_active(1'b1, 20, k);
		chk("one-shot rearm", k, 32'd0);
		reg_wr(OFS_DIV, 32'h9);
		pm.gate(1'b0);
		reg_wr(OFS_CTRL, 32'haf);
		fork
			cnt_active(1'b1, 60, k);
			begin
				pm.gate(1'b1);
				tick(3);
				pm.gate(1'b0);
				tick(2);
				pm.gate(1'b1);
				tick(20);
				pm.gate(1'b0);
				tick(3);
				pm.gate(1'b1);
			end
		join
		chk("repeat width", k, 32'd20);
		reg_wr(OFS_CNT, 32'h55);
		reg_wr(OFS_RES, 32'hffff);
		reg_wr(8'h18, 32'hffff);
		reg_rd(OFS_RES, v);
		chk("result write ignored", v, 32'h0);
		reg_rd(OFS_CNT, v);
		chk("count load", v, 32'h55);
		reg_wr(OFS_DIV, 32'h0);
		reg_rd(OFS_DIV, v);
		chk("divider floor", v, 32'h1);
		@(posedge core_clk);
		reset_n <= 1'b0;
		tick(2);
		reset_n <= 1'b1;
		#1;
		chk("pulse reset", {31'h0, ct_pulse_out}, {31'h0, OUT_RST});
		foreach (ra[i]) begin
			reg_rd(ra[i], v);
			chk("reset value", v, re[i]);
		end
		finish_test();
	end

	// a hang counts against the run rather than stalling it
	initial begin
		#(20000 * 50);
		bad_count++;
		$display("[ERR] watchdog expected done seen timeout");
		finish_test();
	end
endmodule
